// ### hdl/rxcfg_pkg.sv
// Package with offsets, field layouts, reset values and carrier types of the receive-port configuration bank.
package rxcfg_pkg;

  localparam int NPORTS_DEF = 2;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OFS_PORT_SEL = 8'h4C;
  localparam logic [7:0] OFS_STS_ONE  = 8'h4D;
  localparam logic [7:0] OFS_STS_TWO  = 8'h4E;
  localparam logic [7:0] OFS_CAM_STS  = 8'h7A;
  localparam logic [7:0] OFS_EQ_CTL   = 8'hD2;
  localparam logic [7:0] OFS_EQ_MAN   = 8'hD4;
  localparam logic [7:0] OFS_EQ_LIM   = 8'hD5;
  localparam logic [7:0] OFS_SPARE_A  = 8'hD6;
  localparam logic [7:0] OFS_SPARE_B  = 8'hD7;
  localparam logic [7:0] OFS_MASK_HI  = 8'hD8;
  localparam logic [7:0] OFS_MASK_LO  = 8'hD9;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int BYP_BIT      = 0;
  localparam int MLOW_LSB     = 1;
  localparam int MHIGH_LSB    = 5;
  localparam int FLOOR_LSB    = 0;
  localparam int CEIL_LSB     = 4;
  localparam int FLOOREN_BIT  = 2;
  localparam int PSEL_RD_LSB  = 4;
  localparam int MASK_HI_W    = 3;
  localparam int MASK_LO_W    = 7;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic       BYP_RST     = 1'b0;
  localparam logic [2:0] MLOW_RST    = 3'h0;
  localparam logic [2:0] MHIGH_RST   = 3'h3;
  localparam logic [3:0] CEIL_RST    = 4'hF;
  localparam logic [3:0] FLOOR_RST   = 4'h2;
  localparam logic       FLOOREN_RST = 1'b1;
  localparam logic [2:0] MASK_HI_RST = 3'h0;
  localparam logic [6:0] MASK_LO_RST = 7'h00;
  localparam logic [7:0] SPARE_RST   = 8'h00;
  localparam logic [7:0] PSEL_RST    = 8'h01;

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic       bypass;
    logic [2:0] man_high;
    logic [2:0] man_low;
    logic [3:0] ceiling;
    logic [3:0] floor;
    logic       floor_en;
    logic [2:0] mask_hi;
    logic [6:0] mask_lo;
  } rxcfg_cfg_t;

  // Event order matches the concatenation of the high and low mask bytes.
  typedef struct packed {
    logic encode;
    logic sequence_err;
    logic checksum;
    logic line_len;
    logic line_total;
    logic overflow;
    logic camera;
    logic parity;
    logic valid_chg;
    logic lock_chg;
  } rxcfg_evt_t;

  localparam int EVT_W = $bits(rxcfg_evt_t);

  localparam logic [EVT_W-1:0] EVT_GRP_ONE = 10'h187;
  localparam logic [EVT_W-1:0] EVT_GRP_TWO = 10'h270;
  localparam logic [EVT_W-1:0] EVT_GRP_CAM = 10'h008;

  localparam rxcfg_cfg_t CFG_RST = '{
    bypass:   BYP_RST,
    man_high: MHIGH_RST,
    man_low:  MLOW_RST,
    ceiling:  CEIL_RST,
    floor:    FLOOR_RST,
    floor_en: FLOOREN_RST,
    mask_hi:  MASK_HI_RST,
    mask_lo:  MASK_LO_RST
  };

endpackage : rxcfg_pkg

// ### hdl/rxcfg_port.sv
// Equalizer code stepping and interrupt condition latching for one receive port.
`timescale 1ns/10ps
module rxcfg_port (
  input  wire logic                      clk_in,
  input  wire logic                      arst_n_in,
  input  wire rxcfg_pkg::rxcfg_cfg_t     cfg_in,
  input  wire rxcfg_pkg::rxcfg_evt_t     evt_in,
  input  wire logic [rxcfg_pkg::EVT_W-1:0] clr_in,
  input  wire logic                      restart_in,
  input  wire logic                      step_in,
  output logic [rxcfg_pkg::EVT_W-1:0]    lat_out,
  output logic                           irq_out,
  output logic [5:0]                     eq_code_out,
  output logic [3:0]                     adapt_code_out
);
  import rxcfg_pkg::*;

  logic [EVT_W-1:0] lat_r;
  logic [3:0]       adapt_r;
  logic [5:0]       code_r;

  ////////////////////////////////////////////////////////////////////////////////
  wire logic [3:0]       start_code = cfg_in.floor_en ? cfg_in.floor : 4'h0;
  wire logic             can_step   = step_in && !cfg_in.bypass && (adapt_r < cfg_in.ceiling);
  wire logic [3:0]       adapt_nxt  = restart_in ? start_code : (can_step ? adapt_r + 4'h1 : adapt_r);
  wire logic [5:0]       code_nxt   = cfg_in.bypass ? {cfg_in.man_high, cfg_in.man_low}
                                                    : {2'h0, adapt_r};
  // A new event in the clearing cycle survives, so no condition is lost to a read.
  wire logic [EVT_W-1:0] lat_nxt    = (lat_r & ~clr_in) | evt_in;
  wire logic [EVT_W-1:0] en_vec     = {cfg_in.mask_hi, cfg_in.mask_lo};

  assign irq_out        = |(lat_r & en_vec);
  assign lat_out        = lat_r;
  assign eq_code_out    = code_r;
  assign adapt_code_out = adapt_r;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lat_r   <= '0;
      adapt_r <= FLOOR_RST;
      code_r  <= 6'h00;
    end else begin
      lat_r   <= lat_nxt;
      adapt_r <= adapt_nxt;
      code_r  <= code_nxt;
    end
  end

endmodule : rxcfg_port

// ### hdl/rxcfg_top.sv
// Per-receive-port equalizer and interrupt-enable register bank with port-select steering.
`timescale 1ns/10ps

// Function
// - Per-port writes go to every port whose port-select bit is set; reads use the port numbered in port-select bits from bit 4 up.
// - When bypassed, bits 3:1 give the low three code bits; reset zero.
// - When bypassed, bits 7:5 give the high three code bits; reset three.
// - Adaptation never steps past the ceiling in bits 7:4; reset fifteen.
// - With floor start set, adaptation restarts from floor bits 3:0; reset two.
// - Floor start resets to one; when clear adaptation restarts from zero.
// - High mask bit 2 enables the link encoding error interrupt.
// - High mask bit 1 enables the control channel sequence error interrupt.
// - High mask bit 0 enables the control channel checksum error interrupt.
// - High mask bits 7:3 read zero, ignore writes; all enables reset zero.
// - Low mask bit 6 enables the line length change interrupt.
// - Low mask bit 5 enables the lines per frame change interrupt.
// - Low mask bit 4 enables the receive buffer overflow interrupt.
// - Low mask bit 3 enables the camera receiver error interrupt.
// - Low mask bit 2 enables the link parity error interrupt.
// - Low mask bit 1 enables the port valid change interrupt.
// - Low mask bit 0 enables the lock status change interrupt.
// - A latched condition clears only when its status register is read.
module rxcfg_top #(
  parameter int NPORTS = rxcfg_pkg::NPORTS_DEF
) (
  input  wire logic                  clk_in,
  input  wire logic                  arst_n_in,
  input  wire logic [7:0]            reg_addr_in,
  input  wire logic [7:0]            reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic [7:0]                 reg_rdata_out,
  input  wire rxcfg_pkg::rxcfg_evt_t evt_in [NPORTS],
  input  wire logic [NPORTS-1:0]     eq_restart_in,
  input  wire logic [NPORTS-1:0]     eq_step_in,
  output logic [5:0]                 eq_code_out [NPORTS],
  output logic [3:0]                 adapt_code_out [NPORTS],
  output logic                       irq_out
);
  import rxcfg_pkg::*;

  localparam int RDW = (NPORTS > 1) ? $clog2(NPORTS) : 1;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic rxcfg_cfg_t write_cfg(input rxcfg_cfg_t cur,
                                           input logic [7:0] addr,
                                           input logic [7:0] data);
    rxcfg_cfg_t nxt;
    nxt = cur;
    if (addr == OFS_EQ_CTL) begin
      nxt.floor_en = data[FLOOREN_BIT];
    end
    if (addr == OFS_EQ_MAN) begin
      nxt.man_high = data[MHIGH_LSB +: 3];
      nxt.man_low  = data[MLOW_LSB +: 3];
      nxt.bypass   = data[BYP_BIT];
    end
    if (addr == OFS_EQ_LIM) begin
      nxt.ceiling = data[CEIL_LSB +: 4];
      nxt.floor   = data[FLOOR_LSB +: 4];
    end
    if (addr == OFS_MASK_HI) begin
      nxt.mask_hi = data[MASK_HI_W-1:0];
    end
    if (addr == OFS_MASK_LO) begin
      nxt.mask_lo = data[MASK_LO_W-1:0];
    end
    return nxt;
  endfunction : write_cfg

  function automatic logic [7:0] read_port(input rxcfg_cfg_t cfg,
                                           input logic [7:0] spa,
                                           input logic [7:0] spb,
                                           input logic [EVT_W-1:0] lat,
                                           input logic [7:0] addr);
    logic [7:0] r;
    r = 8'h00;
    unique case (addr)
      OFS_EQ_CTL: begin
        r[FLOOREN_BIT] = cfg.floor_en;
      end
      OFS_EQ_MAN: begin
        r[MHIGH_LSB +: 3] = cfg.man_high;
        r[MLOW_LSB +: 3]  = cfg.man_low;
        r[BYP_BIT]        = cfg.bypass;
      end
      OFS_EQ_LIM: begin
        r[CEIL_LSB +: 4]  = cfg.ceiling;
        r[FLOOR_LSB +: 4] = cfg.floor;
      end
      OFS_SPARE_A: begin
        r = spa;
      end
      OFS_SPARE_B: begin
        r = spb;
      end
      OFS_MASK_HI: begin
        r[MASK_HI_W-1:0] = cfg.mask_hi;
      end
      OFS_MASK_LO: begin
        r[MASK_LO_W-1:0] = cfg.mask_lo;
      end
      OFS_STS_ONE: begin
        r[4:0] = {lat[8], lat[7], lat[2], lat[1], lat[0]};
      end
      OFS_STS_TWO: begin
        r[3:0] = {lat[9], lat[6], lat[5], lat[4]};
      end
      OFS_CAM_STS: begin
        r[0] = lat[3];
      end
      default: begin
        r = 8'h00;
      end
    endcase
    return r;
  endfunction : read_port

  // Each status register clears only the conditions it reports.
  function automatic logic [EVT_W-1:0] clear_mask(input logic [7:0] addr);
    logic [EVT_W-1:0] m;
    m = '0;
    if (addr == OFS_STS_ONE) begin
      m = EVT_GRP_ONE;
    end
    if (addr == OFS_STS_TWO) begin
      m = EVT_GRP_TWO;
    end
    if (addr == OFS_CAM_STS) begin
      m = EVT_GRP_CAM;
    end
    return m;
  endfunction : clear_mask

  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0]       psel_r;
  logic [7:0]       rdata_r;
  logic             irq_r;
  rxcfg_cfg_t       cfg_r     [NPORTS];
  rxcfg_cfg_t       cfg_nxt   [NPORTS];
  logic [7:0]       spare_a_r [NPORTS];
  logic [7:0]       spare_b_r [NPORTS];
  logic [7:0]       port_rd   [NPORTS];
  logic [EVT_W-1:0] lat       [NPORTS];
  logic [EVT_W-1:0] clr       [NPORTS];
  logic [NPORTS-1:0] port_irq;

  wire logic [RDW-1:0] rd_idx  = psel_r[PSEL_RD_LSB +: RDW];
  wire logic           rd_ok   = (int'(rd_idx) < NPORTS);
  wire logic           hit_sel = (reg_addr_in == OFS_PORT_SEL);
  wire logic [7:0]     rd_nxt  = hit_sel ? psel_r : (rd_ok ? port_rd[rd_idx] : 8'h00);
  wire rxcfg_cfg_t     rd_cfg  = rd_ok ? cfg_r[rd_idx] : CFG_RST;

  assign reg_rdata_out = rdata_r;
  assign irq_out       = irq_r;

  ////////////////////////////////////////////////////////////////////////////////
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    // A write lands in every port whose select bit is set, so broadcast writes are possible.
    wire logic wr_here = reg_wr_in && psel_r[p];
    wire logic rd_here = reg_rd_in && (rd_idx == RDW'(p));

    assign cfg_nxt[p] = wr_here ? write_cfg(cfg_r[p], reg_addr_in, reg_wdata_in) : cfg_r[p];
    assign port_rd[p] = read_port(cfg_r[p], spare_a_r[p], spare_b_r[p], lat[p], reg_addr_in);
    assign clr[p]     = rd_here ? clear_mask(reg_addr_in) : '0;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        cfg_r[p]     <= CFG_RST;
        spare_a_r[p] <= SPARE_RST;
        spare_b_r[p] <= SPARE_RST;
      end else begin
        cfg_r[p] <= cfg_nxt[p];
        if (wr_here && reg_addr_in == OFS_SPARE_A) begin
          spare_a_r[p] <= reg_wdata_in;
        end
        if (wr_here && reg_addr_in == OFS_SPARE_B) begin
          spare_b_r[p] <= reg_wdata_in;
        end
      end
    end

    rxcfg_port u_port (
      .clk_in         (clk_in),
      .arst_n_in      (arst_n_in),
      .cfg_in         (cfg_r[p]),
      .evt_in         (evt_in[p]),
      .clr_in         (clr[p]),
      .restart_in     (eq_restart_in[p]),
      .step_in        (eq_step_in[p]),
      .lat_out        (lat[p]),
      .irq_out        (port_irq[p]),
      .eq_code_out    (eq_code_out[p]),
      .adapt_code_out (adapt_code_out[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reads are answered one cycle after the strobe; the data holds until the next read.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      psel_r  <= PSEL_RST;
      rdata_r <= 8'h00;
      irq_r   <= 1'b0;
    end else begin
      if (reg_wr_in && hit_sel) begin
        psel_r <= reg_wdata_in;
      end
      if (reg_rd_in) begin
        rdata_r <= rd_nxt;
      end
      irq_r <= |port_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  property p_rd_route;
    reg_rd_in && reg_addr_in == OFS_EQ_LIM && rd_ok |=>
      reg_rdata_out == {$past(rd_cfg.ceiling), $past(rd_cfg.floor)};
  endproperty
  a_rd_route: assert property (p_rd_route) else $error("limit read not from selected port");

  property p_mask_hi_zero;
    reg_rd_in && reg_addr_in == OFS_MASK_HI |=> reg_rdata_out[7:3] == 5'h00;
  endproperty
  a_mask_hi_zero: assert property (p_mask_hi_zero) else $error("upper mask bits not zero");

  property p_irq_rise;
    $rose(|port_irq) |=> irq_out;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt missed an enabled condition");

  property p_irq_fall;
    (port_irq == '0) [*2] |-> !irq_out;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt held with nothing enabled");

  for (genvar p = 0; p < NPORTS; p++) begin : g_chk
    sequence s_read_one;
      reg_rd_in && reg_addr_in == OFS_STS_ONE && rd_idx == RDW'(p);
    endsequence

    sequence s_floor_restart;
      eq_restart_in[p] && cfg_r[p].floor_en;
    endsequence

    property p_wr_route;
      reg_wr_in && !psel_r[p] |=> cfg_r[p] == $past(cfg_r[p]);
    endproperty
    a_wr_route: assert property (p_wr_route) else $error("write reached an unselected port");

    property p_hold_bypass;
      cfg_r[p].bypass && !eq_restart_in[p] |=> adapt_code_out[p] == $past(adapt_code_out[p]);
    endproperty
    a_hold_bypass: assert property (p_hold_bypass) else $error("adaptation moved while bypassed");

    property p_man_low;
      cfg_r[p].bypass |=> eq_code_out[p][2:0] == $past(cfg_r[p].man_low);
    endproperty
    a_man_low: assert property (p_man_low) else $error("low manual code not applied");

    property p_man_high;
      cfg_r[p].bypass |=> eq_code_out[p][5:3] == $past(cfg_r[p].man_high);
    endproperty
    a_man_high: assert property (p_man_high) else $error("high manual code not applied");

    property p_ceiling;
      eq_step_in[p] && !eq_restart_in[p] && adapt_code_out[p] >= cfg_r[p].ceiling |=>
        adapt_code_out[p] == $past(adapt_code_out[p]);
    endproperty
    a_ceiling: assert property (p_ceiling) else $error("adaptation stepped past ceiling");

    property p_floor_start;
      s_floor_restart ##1 (!cfg_r[p].bypass && !eq_restart_in[p] && !eq_step_in[p]) |=>
        eq_code_out[p] == {2'h0, $past(adapt_code_out[p])} && adapt_code_out[p] == $past(cfg_r[p].floor, 2);
    endproperty
    a_floor_start: assert property (p_floor_start) else $error("restart did not use the floor");

    property p_zero_start;
      eq_restart_in[p] && !cfg_r[p].floor_en |=> adapt_code_out[p] == 4'h0;
    endproperty
    a_zero_start: assert property (p_zero_start) else $error("restart not from zero");

    property p_read_clear;
      s_read_one |=> (lat[p] & EVT_GRP_ONE) == ($past(evt_in[p]) & EVT_GRP_ONE);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status read did not clear");

    property p_no_clear;
      !reg_rd_in |=> (lat[p] & $past(lat[p])) == $past(lat[p]);
    endproperty
    a_no_clear: assert property (p_no_clear) else $error("condition cleared without a read");

    property p_lock_gate;
      lat[p][0] && cfg_r[p].mask_lo[0] |-> port_irq[p] ##1 irq_out;
    endproperty
    a_lock_gate: assert property (p_lock_gate) else $error("lock change did not interrupt");

    property p_encode_gate;
      lat[p][9] && cfg_r[p].mask_hi[2] |-> port_irq[p];
    endproperty
    a_encode_gate: assert property (p_encode_gate) else $error("encode error did not interrupt");

    property p_seq_gate;
      lat[p][8] && cfg_r[p].mask_hi[1] |-> port_irq[p];
    endproperty
    a_seq_gate: assert property (p_seq_gate) else $error("sequence error did not interrupt");

    property p_checksum_gate;
      lat[p][7] && cfg_r[p].mask_hi[0] |-> port_irq[p];
    endproperty
    a_checksum_gate: assert property (p_checksum_gate) else $error("checksum error did not interrupt");

    property p_line_len_gate;
      lat[p][6] && cfg_r[p].mask_lo[6] |-> port_irq[p];
    endproperty
    a_line_len_gate: assert property (p_line_len_gate) else $error("line length change did not interrupt");

    property p_line_total_gate;
      lat[p][5] && cfg_r[p].mask_lo[5] |-> port_irq[p];
    endproperty
    a_line_total_gate: assert property (p_line_total_gate) else $error("line total change did not interrupt");

    property p_overflow_gate;
      lat[p][4] && cfg_r[p].mask_lo[4] |-> port_irq[p];
    endproperty
    a_overflow_gate: assert property (p_overflow_gate) else $error("overflow did not interrupt");

    property p_camera_gate;
      lat[p][3] && cfg_r[p].mask_lo[3] |-> port_irq[p];
    endproperty
    a_camera_gate: assert property (p_camera_gate) else $error("camera error did not interrupt");

    property p_parity_gate;
      lat[p][2] && cfg_r[p].mask_lo[2] |-> port_irq[p];
    endproperty
    a_parity_gate: assert property (p_parity_gate) else $error("parity error did not interrupt");

    property p_valid_gate;
      lat[p][1] && cfg_r[p].mask_lo[1] |-> port_irq[p];
    endproperty
    a_valid_gate: assert property (p_valid_gate) else $error("valid change did not interrupt");

    // A latched condition with its enable clear must stay silent, or masking is useless to the host.
    property p_masked_quiet;
      (lat[p] & {cfg_r[p].mask_hi, cfg_r[p].mask_lo}) == '0 |-> !port_irq[p];
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("interrupt raised with nothing enabled");

    property p_step_up;
      eq_step_in[p] && !eq_restart_in[p] && !cfg_r[p].bypass && adapt_code_out[p] < cfg_r[p].ceiling |=>
        adapt_code_out[p] == $past(adapt_code_out[p]) + 4'h1;
    endproperty
    a_step_up: assert property (p_step_up) else $error("adaptation did not step while active");
  end

endmodule : rxcfg_top

// ### test/rxcfg_host.sv
// Host model that issues single-byte register writes and reads on the internal register port.
`timescale 1ns/10ps
module rxcfg_host (
  input  wire logic       clk_in,
  output logic [7:0]      reg_addr_out,
  output logic [7:0]      reg_wdata_out,
  output logic            reg_wr_out,
  output logic            reg_rd_out
);
  import rxcfg_pkg::*;

  initial begin
    reg_addr_out  = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // A ceiling at or below a floor under 15 is raised to one above the floor, because a careful host never programs that pair.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == OFS_EQ_LIM && v[7:4] <= v[3:0] && v[3:0] != 4'hF) begin
      v[7:4] = v[3:0] + 4'h1;
    end
    @(posedge clk_in);
    reg_addr_out  <= a;
    reg_wdata_out <= v;
    reg_wr_out    <= 1'b1;
    @(posedge clk_in);
    reg_wr_out    <= 1'b0;
    reg_addr_out  <= ~a;
    reg_wdata_out <= ~v;
  endtask : wr

  // Released address lines show the inverse so that a stale value is never read as valid.
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    reg_addr_out <= a;
    reg_rd_out   <= 1'b1;
    @(posedge clk_in);
    reg_rd_out   <= 1'b0;
    reg_addr_out <= ~a;
  endtask : rd

endmodule : rxcfg_host

// ### test/tb_rxcfg_top.sv
// Self-checking bench for the receive-port equalizer and interrupt-enable register bank.
`timescale 1ns/10ps
module tb_rxcfg_top;
  import rxcfg_pkg::*;
  localparam int NP = 2;
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, irq;
  logic        rd_pend = 1'b0;
  rxcfg_evt_t  evt [NP];
  logic [NP-1:0] restart = '0;
  logic [NP-1:0] step = '0;
  logic [5:0]  eq_code [NP];
  logic [3:0]  adapt [NP];
  logic [7:0]  exp_q [$];
  logic [7:0]  ofs_q [$];
  int          errors = 0;
  int          compares = 0;
  logic [7:0]  rst_ofs [9] = '{8'h4C, 8'hD2, 8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hD8, 8'hD9, 8'h10};
  logic [7:0]  rst_val [9] = '{8'h01, 8'h04, 8'h60, 8'hF2, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  sts_ofs [10] = '{8'h4D, 8'h4D, 8'h4D, 8'h7A, 8'h4E, 8'h4E, 8'h4E, 8'h4D, 8'h4D, 8'h4E};
  logic [2:0]  sts_bit [10] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h3};
  logic [7:0]  d0;
  logic [3:0]  fl, ce;
  logic [2:0]  mh, ml;
  logic [9:0]  m;
  int          p;

  rxcfg_host host (.clk_in(clk_in), .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata),
                   .reg_wr_out(reg_wr), .reg_rd_out(reg_rd));

  rxcfg_top #(.NPORTS(NP)) dut (
    .clk_in         (clk_in),
    .arst_n_in      (arst_n_in),
    .reg_addr_in    (reg_addr),
    .reg_wdata_in   (reg_wdata),
    .reg_wr_in      (reg_wr),
    .reg_rd_in      (reg_rd),
    .reg_rdata_out  (reg_rdata),
    .evt_in         (evt),
    .eq_restart_in  (restart),
    .eq_step_in     (step),
    .eq_code_out    (eq_code),
    .adapt_code_out (adapt),
    .irq_out        (irq)
  );

  always #5 clk_in = ~clk_in;

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // Read data lands one cycle after the read edge, so it is taken at the following falling edge.
  always @(posedge clk_in) rd_pend <= reg_rd;
  always @(negedge clk_in) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("[ERR] read data expected none seen %h", reg_rdata);
      end else begin
        chk($sformatf("reg %h", ofs_q.pop_front()), exp_q.pop_front(), reg_rdata);
      end
    end
  end

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    ofs_q.push_back(a);
    host.rd(a);
  endtask : rd

  task automatic at_neg(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask : at_neg

  task automatic pulse_restart;
    @(posedge clk_in) restart <= '1;
    @(posedge clk_in) restart <= '0;
    at_neg(1);
  endtask : pulse_restart

  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  initial begin
    #500000;
    errors++;
    $display("[ERR] run length expected bounded seen hang");
    conclude();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < NP; i++) evt[i] = '0;
    void'($urandom(48565));
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    at_neg(1);
    for (int i = 0; i < NP; i++) begin
      chk("eq code", 8'h02, {2'b00, eq_code[i]});
      chk("adapt code", 8'h02, {4'h0, adapt[i]});
    end
    chk("irq", 8'h00, {7'h0, irq});
    for (int i = 0; i < 9; i++) rd(rst_ofs[i], rst_val[i]);
    at_neg(2);
    $display("Test reset values done");

    d0 = 8'($urandom());
    host.wr(OFS_PORT_SEL, 8'h01);
    host.wr(OFS_SPARE_A, d0);
    host.wr(OFS_PORT_SEL, 8'h12);
    host.wr(OFS_SPARE_A, ~d0);
    host.wr(OFS_MASK_HI, 8'hFF);
    host.wr(OFS_MASK_LO, 8'hFF);
    rd(OFS_SPARE_A, ~d0);
    rd(OFS_MASK_HI, 8'h07);
    rd(OFS_MASK_LO, 8'h7F);
    host.wr(OFS_PORT_SEL, 8'h01);
    rd(OFS_SPARE_A, d0);
    rd(OFS_MASK_HI, 8'h00);
    host.wr(OFS_PORT_SEL, 8'h03);
    host.wr(OFS_MASK_HI, 8'h00);
    host.wr(OFS_MASK_LO, 8'h00);
    at_neg(2);
    $display("Test port steering done");

    fl = 4'($urandom_range(13));
    ce = fl + 4'h1 + 4'($urandom_range(14 - fl));
    host.wr(OFS_EQ_LIM, {ce, fl});
    rd(OFS_EQ_LIM, {ce, fl});
    pulse_restart();
    chk("adapt floor", {4'h0, fl}, {4'h0, adapt[0]});
    chk("eq floor", {4'h0, fl}, {2'b00, eq_code[1]});
    @(posedge clk_in) step <= '1;
    repeat (16) @(posedge clk_in);
    step <= '0;
    at_neg(1);
    for (int i = 0; i < NP; i++) chk("adapt ceiling", {4'h0, ce}, {4'h0, adapt[i]});
    chk("eq ceiling", {4'h0, ce}, {2'b00, eq_code[0]});
    host.wr(OFS_EQ_CTL, 8'hFF);
    rd(OFS_EQ_CTL, 8'h04);
    host.wr(OFS_EQ_CTL, 8'h00);
    pulse_restart();
    chk("adapt zero start", 8'h00, {4'h0, adapt[1]});
    mh = 3'($urandom());
    ml = 3'($urandom());
    host.wr(OFS_EQ_MAN, {mh, 1'b1, ml, 1'b1});
    rd(OFS_EQ_MAN, {mh, 1'b0, ml, 1'b1});
    @(posedge clk_in) step <= '1;
    repeat (4) @(posedge clk_in);
    step <= '0;
    at_neg(1);
    chk("eq manual", {2'b00, mh, ml}, {2'b00, eq_code[0]});
    chk("adapt bypassed", 8'h00, {4'h0, adapt[0]});
    $display("Test equalizer done");

    for (int i = 0; i < EVT_W; i++) begin
      p = $urandom_range(NP - 1);
      host.wr(OFS_PORT_SEL, 8'(p << 4) | 8'(1 << p));
      m = 10'h001 << i;
      @(posedge clk_in) evt[p] <= rxcfg_evt_t'(m);
      @(posedge clk_in) evt[p] <= '0;
      at_neg(2);
      chk("irq masked", 8'h00, {7'h0, irq});
      host.wr(OFS_MASK_HI, {5'h00, m[9:7]});
      host.wr(OFS_MASK_LO, {1'b0, m[6:0]});
      at_neg(2);
      chk("irq enabled", 8'h01, {7'h0, irq});
      rd((sts_ofs[i] == OFS_CAM_STS) ? OFS_STS_ONE : OFS_CAM_STS, 8'h00);
      at_neg(2);
      chk("irq held", 8'h01, {7'h0, irq});
      rd(sts_ofs[i], 8'h01 << sts_bit[i]);
      at_neg(2);
      chk("irq cleared", 8'h00, {7'h0, irq});
      host.wr(OFS_MASK_HI, 8'h00);
      host.wr(OFS_MASK_LO, 8'h00);
    end
    at_neg(2);
    $display("Test interrupt enables done");
    conclude();
  end

endmodule : tb_rxcfg_top
